// [sbi_defines.svh]
// Offsets, field positions, reset values and counts of the startup and ID register group
// Behaviour
// R01 - Five-bit boot retry count, resets to one
// R02 - Total boot arbitration attempts equal count plus one
// R03 - Limit bit set loads only eight internal bytes
// R04 - Disable bit clear loads boot memory, overwriting
// R05 - Wide select sends two memory address bytes
// R06 - Seven-bit field gives boot memory bus address
// R07 - Software writes zero to reserved startup bit
// R08 - Eleven-bit configuration code, reset from factory
// R09 - Configuration code writable anytime, reads back; the code accepts writes only after the boot load has finished
// R10 - Control port accesses ignored during boot load
// R11 - Abort load on no-acknowledge or checksum mismatch
// R12 - Revision and part code readable at fixed bits
`ifndef SBI_DEFINES_SVH
`define SBI_DEFINES_SVH

// Register offsets on the serial control port
`define SBI_OFF_STARTUP_CONTROL   16'h0000
`define SBI_OFF_BOOT_EEPROM_ADDR  16'h0001
`define SBI_OFF_REV_PART_HIGH     16'h0002
`define SBI_OFF_PART_MIDDLE       16'h0003
`define SBI_OFF_PART_LOW_CFG_HIGH 16'h0004
`define SBI_OFF_CONFIG_CODE_LOW   16'h0005
`define SBI_NUM_REGS              6

// Field positions inside startup_control
`define SBI_POS_RETRY_MSB         7
`define SBI_POS_RETRY_LSB         3
`define SBI_POS_RSVD              2
`define SBI_POS_ROM_LIMIT         1
`define SBI_POS_EXT_DISABLE       0
// Field positions inside boot_eeprom_address
`define SBI_POS_WIDE              7
`define SBI_POS_BUS_ADDR_MSB      6

// Readable-bit masks; reserved bits read as zero
`define SBI_MASK_STARTUP          8'hFB
`define SBI_MASK_CONFIG_LOW       8'hFE
`define SBI_MASK_FULL             8'hFF

// Reset values before the internal memory load
`define SBI_RST_STARTUP           8'h09
`define SBI_RST_BOOT_ADDR         8'h50

// Internal memory and boot image layout
`define SBI_ROM_LIMIT_BYTES       8'h08
`define SBI_ROM_FULL_BYTES        8'hE0
`define SBI_IMG_FIRST_DATA        8'h08
`define SBI_IMG_CHECKSUM          8'hE0

`endif

// [sbi_pkg.sv]
// Types shared by the startup and ID register group
package sbi_pkg;

  // Boot sequencer states
  typedef enum logic [2:0] {
    SBI_ST_RESET,
    SBI_ST_ROM_REQ,
    SBI_ST_ROM_WAIT,
    SBI_ST_EXT_START,
    SBI_ST_EXT_WAIT,
    SBI_ST_DONE
  } sbi_state_e;

  // Outcome of one boot memory read attempt, reported by the bus master engine
  typedef enum logic [2:0] {
    SBI_EXT_OK,
    SBI_EXT_ARB_LOST,
    SBI_EXT_NACK,
    SBI_EXT_CRC_BAD,
    SBI_EXT_TIMEOUT
  } sbi_ext_status_e;

  // Request to the bus master engine
  typedef struct packed {
    logic       start;      // One-cycle pulse begins an attempt
    logic [6:0] busAddr;    // Bus address of the boot memory
    logic       twoAddrBytes; // Send two address bytes
  } sbi_ext_req_s;

  // Answer from the bus master engine
  typedef struct packed {
    logic            byteValid; // One-cycle pulse with a read byte
    logic [7:0]      offset;    // Image offset of that byte
    logic [7:0]      data;      // Byte read
    logic            done;      // One-cycle pulse ends the attempt
    sbi_ext_status_e status;    // Valid with done
  } sbi_ext_rsp_s;

  // Configuration byte written to the rest of the device
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } sbi_cfg_wr_s;

endpackage

// [sbi_retry_ctr.sv]
// Counter of remaining bus arbitration retries for the boot read
`timescale 1ns/1ps
`default_nettype none
module sbi_retry_ctr #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  input  wire logic             consume,
  // Status
  output logic                  canRetry,
  output logic [WIDTH-1:0]      remaining
);
  import sbi_pkg::*;

  logic [WIDTH-1:0] count_reg;  // Retries still allowed
  logic [WIDTH-1:0] count_next;

  // The first attempt is not charged; only a retry consumes one
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = loadValue; // R02
    end else if (consume && (count_reg != '0)) begin
      count_next = count_reg - 1'b1; // R02
    end
  end

  // Registered count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign canRetry  = (count_reg != '0);
  assign remaining = count_reg;
endmodule
`default_nettype wire

// [sbi_startup_regs.sv]
// Startup control and ID registers with the power-up boot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sbi_defines.svh"
module sbi_startup_regs #(
  parameter logic [3:0]  REVISION_CODE = 4'h1,      // Arbitrary value
  parameter logic [15:0] PART_CODE     = 16'h1234,  // Arbitrary value
  parameter logic [10:0] CONFIG_CODE   = 11'h000,   // Factory code before load
  parameter logic [7:0]  ROM_FULL_BYTES = `SBI_ROM_FULL_BYTES
) (
  // Clock, reset and enable
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  // Serial control port register access
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  input  wire logic [15:0]          regAddr,
  input  wire logic [7:0]           regWdata,
  output logic [7:0]                regRdata,
  output logic                      regRdValid,
  output logic                      regBusy,
  // Internal one-time-programmable memory
  output logic                      romRdReq,
  output logic [7:0]                romRdAddr,
  input  wire logic                 romRdValid,
  input  wire logic [7:0]           romRdData,
  // Boot memory bus master engine
  output sbi_pkg::sbi_ext_req_s     extReq,
  input  wire sbi_pkg::sbi_ext_rsp_s extRsp,
  // Configuration writes to the rest of the device
  output sbi_pkg::sbi_cfg_wr_s      cfgWr,
  // Boot status
  input  wire logic                 bootFailClear,
  output logic                      bootDone,
  output logic                      bootLoadFailed,
  output logic [10:0]               configCode
);
  import sbi_pkg::*;

  localparam int NR = `SBI_NUM_REGS;

  // Reset value of each register byte
  function automatic logic [7:0] resetValue(input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      0:       v = `SBI_RST_STARTUP;
      1:       v = `SBI_RST_BOOT_ADDR;
      2:       v = {REVISION_CODE, PART_CODE[15:12]};
      3:       v = PART_CODE[11:4];
      4:       v = {PART_CODE[3:0], CONFIG_CODE[10:7]};
      5:       v = {CONFIG_CODE[6:0], 1'b0};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Storable and readable bits of each register; reserved bits stay zero
  function automatic logic [7:0] bitMask(input logic [15:0] addr);
    logic [7:0] m;
    m = `SBI_MASK_FULL;
    case (addr)
      `SBI_OFF_STARTUP_CONTROL: m = `SBI_MASK_STARTUP; // R07
      `SBI_OFF_CONFIG_CODE_LOW: m = `SBI_MASK_CONFIG_LOW;
      default:                  m = `SBI_MASK_FULL;
    endcase
    return m;
  endfunction

  // Address falls inside this group
  function automatic logic inGroup(input logic [15:0] addr);
    return (addr < 16'(NR));
  endfunction

  // Register bytes and sequencer state
  logic [7:0]  regs_reg [NR];      // Register file
  logic [7:0]  regs_next [NR];
  sbi_state_e  state_reg;          // Boot sequencer state
  sbi_state_e  state_next;
  logic [7:0]  romAddr_reg;        // Next internal memory byte
  logic [7:0]  romAddr_next;
  logic        romReq_reg;
  logic        romReq_next;
  sbi_ext_req_s extReq_reg;
  sbi_ext_req_s extReq_next;
  sbi_cfg_wr_s cfgWr_reg;
  sbi_cfg_wr_s cfgWr_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rdValid_reg;
  logic        rdValid_next;
  logic        failed_reg;         // Sticky boot failure flag
  logic        failed_next;

  // Field views
  logic [4:0]  retryCount;         // Retries after the first attempt
  logic        romLimit;           // Load only the first bytes internally
  logic        extDisable;         // Skip the boot memory
  logic        wideSelect;         // Two address bytes
  logic [6:0]  busAddress;         // Boot memory bus address
  logic        bootActive;         // Load in progress
  logic [7:0]  romLastByte;        // Bytes loaded from internal memory
  logic        retryLoad;          // Arm the retry counter
  logic        retryUse;           // One retry taken
  logic        retryLeft;          // Retry counter not empty

  assign retryCount = regs_reg[0][`SBI_POS_RETRY_MSB:`SBI_POS_RETRY_LSB]; // R01
  assign romLimit   = regs_reg[0][`SBI_POS_ROM_LIMIT];
  assign extDisable = regs_reg[0][`SBI_POS_EXT_DISABLE];
  assign wideSelect = regs_reg[1][`SBI_POS_WIDE];
  assign busAddress = regs_reg[1][`SBI_POS_BUS_ADDR_MSB:0]; // R06
  assign configCode = {regs_reg[4][3:0], regs_reg[5][7:1]}; // R08
  assign bootActive = (state_reg != SBI_ST_DONE);
  // The limit bit is itself loaded from byte 0, so it steers the rest of the load
  assign romLastByte = romLimit ? `SBI_ROM_LIMIT_BYTES : ROM_FULL_BYTES; // R03

  // Retry bookkeeping kept apart so the attempt count stays easy to audit
  sbi_retry_ctr #(
    .WIDTH(5)
  ) u_retry (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .load     (retryLoad),
    .loadValue(retryCount),
    .consume  (retryUse),
    .canRetry (retryLeft),
    .remaining()
  );

  // Next values: register access, internal load, boot memory load
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      regs_next[i] = regs_reg[i];
    end
    state_next   = state_reg;
    romAddr_next = romAddr_reg;
    romReq_next  = 1'b0;
    extReq_next  = extReq_reg;
    extReq_next.start = 1'b0;
    cfgWr_next   = '0;
    rdata_next   = rdata_reg;
    rdValid_next = 1'b0;
    failed_next  = failed_reg;
    retryLoad    = 1'b0;
    retryUse     = 1'b0;

    // Control port is served only once the load has finished
    if (!bootActive) begin // R10
      if (regWr && inGroup(regAddr)) begin
        // Configuration code bytes are plain storage, writable once the load has finished
        regs_next[regAddr[2:0]] = regWdata & bitMask(regAddr); // R09
      end
      if (regRd) begin
        rdValid_next = 1'b1;
        rdata_next   = inGroup(regAddr) ? (regs_reg[regAddr[2:0]] & bitMask(regAddr)) : 8'h00; // R12
      end
    end

    case (state_reg)
      SBI_ST_RESET: begin
        romAddr_next = 8'h00;
        state_next   = SBI_ST_ROM_REQ;
      end
      SBI_ST_ROM_REQ: begin
        romReq_next = 1'b1;
        state_next  = SBI_ST_ROM_WAIT;
      end
      SBI_ST_ROM_WAIT: begin
        if (romRdValid) begin
          if (inGroup({8'h00, romAddr_reg})) begin
            // Factory values for startup and ID bytes
            regs_next[romAddr_reg[2:0]] = romRdData & bitMask({8'h00, romAddr_reg}); // R08
          end else begin
            cfgWr_next = '{valid: 1'b1, addr: romAddr_reg, data: romRdData};
          end
          romAddr_next = romAddr_reg + 8'h01;
          if ((romAddr_reg + 8'h01) >= romLastByte) begin // R03
            state_next = SBI_ST_EXT_START;
          end else begin
            state_next = SBI_ST_ROM_REQ;
          end
        end
      end
      SBI_ST_EXT_START: begin
        if (extDisable) begin
          state_next = SBI_ST_DONE; // R04
        end else begin
          retryLoad   = 1'b1; // R02
          extReq_next = '{start: 1'b1, busAddr: busAddress, twoAddrBytes: wideSelect}; // R05
          state_next  = SBI_ST_EXT_WAIT;
        end
      end
      SBI_ST_EXT_WAIT: begin
        // Image bytes overwrite what the internal memory put in place
        if (extRsp.byteValid && (extRsp.offset >= `SBI_IMG_FIRST_DATA)
            && (extRsp.offset < `SBI_IMG_CHECKSUM)) begin
          cfgWr_next = '{valid: 1'b1, addr: extRsp.offset, data: extRsp.data}; // R04
        end
        if (extRsp.done) begin
          case (extRsp.status)
            SBI_EXT_OK: begin
              state_next = SBI_ST_DONE;
            end
            SBI_EXT_ARB_LOST: begin
              if (retryLeft) begin
                retryUse          = 1'b1; // R01
                extReq_next.start = 1'b1;
              end else begin
                failed_next = 1'b1;
                state_next  = SBI_ST_DONE;
              end
            end
            default: begin
              // Bytes not yet written keep their defaults
              failed_next = 1'b1; // R11
              state_next  = SBI_ST_DONE;
            end
          endcase
        end
      end
      SBI_ST_DONE: begin
        state_next = SBI_ST_DONE;
      end
      default: begin
        state_next = SBI_ST_DONE;
      end
    endcase

    // A failure in the same cycle as a clear keeps the flag set
    if (bootFailClear && !(failed_next && !failed_reg)) begin
      failed_next = 1'b0;
    end
  end

  // State registers; reset gives constants, the load then fills in factory values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NR; i++) begin
        regs_reg[i] <= resetValue(i);
      end
      state_reg   <= SBI_ST_RESET;
      romAddr_reg <= 8'h00;
      romReq_reg  <= 1'b0;
      extReq_reg  <= '0;
      cfgWr_reg   <= '0;
      rdata_reg   <= 8'h00;
      rdValid_reg <= 1'b0;
      failed_reg  <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NR; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      state_reg   <= state_next;
      romAddr_reg <= romAddr_next;
      romReq_reg  <= romReq_next;
      extReq_reg  <= extReq_next;
      cfgWr_reg   <= cfgWr_next;
      rdata_reg   <= rdata_next;
      rdValid_reg <= rdValid_next;
      failed_reg  <= failed_next;
    end
  end

  // Outputs
  assign regRdata       = rdata_reg;
  assign regRdValid     = rdValid_reg;
  assign regBusy        = bootActive;
  assign romRdReq       = romReq_reg;
  assign romRdAddr      = romAddr_reg;
  assign extReq         = extReq_reg;
  assign cfgWr          = cfgWr_reg;
  assign bootDone       = !bootActive;
  assign bootLoadFailed = failed_reg;
endmodule
`default_nettype wire

// [sbi_startup_regs_checker.sv]
// Port assertions for the startup and ID register group
`timescale 1ns/1ps
`default_nettype none
module sbi_startup_regs_checker
  import sbi_pkg::*;
#(
  parameter logic [7:0] ROM_FULL_BYTES = 8'hE0  // Internal load length
) (
  // Clock, reset and control port
  input wire logic         clk, reset, ce, regWr, regRd, regRdValid, regBusy,
  input wire logic [15:0]  regAddr,
  input wire logic [7:0]   regWdata, regRdata,
  // Boot side and status
  input wire logic         romRdReq, romRdValid, bootFailClear, bootDone, bootLoadFailed,
  input wire logic [7:0]   romRdAddr, romRdData,
  input wire sbi_ext_req_s extReq,
  input wire sbi_ext_rsp_s extRsp,
  input wire sbi_cfg_wr_s  cfgWr,
  input wire logic [10:0]  configCode
);
  // Single domain, so one clock and one disable serve all
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  done_level_a: assert property (bootDone == !regBusy) else $error("done level wrong");
  busy_drop_a: assert property (regBusy |=> !regRdValid) else $error("busy read answered");
  read_answer_a: assert property (regRd && ce && !regBusy |=> regRdValid)
    else $error("read not answered");
  rsvd_zero_a: assert property (regRd && ce && !regBusy && regAddr == 16'h0000
    |=> !regRdata[2]) else $error("reserved bit reads one");
  code_write_a: assert property (regWr && ce && !regBusy && regAddr == 16'h0005
    |=> configCode[6:0] == $past(regWdata[7:1])) else $error("code not written");
  rom_range_a: assert property (romRdReq |-> romRdAddr < ROM_FULL_BYTES)
    else $error("memory read past end");
  cfg_range_a: assert property (cfgWr.valid |-> cfgWr.addr >= 8'h06 && cfgWr.addr < 8'hE0)
    else $error("image byte out of range");
  byte_fwd_a: assert property (extRsp.byteValid && regBusy && extRsp.offset >= 8'h08
    && extRsp.offset < 8'hE0 |=> cfgWr.valid && cfgWr.addr == $past(extRsp.offset)
    && cfgWr.data == $past(extRsp.data))
    else $error("byte not forwarded");
  retry_next_a: assert property (extRsp.done && regBusy && extRsp.status == SBI_EXT_ARB_LOST
    |=> extReq.start != bootLoadFailed) else $error("retry step wrong");
  fail_stop_a: assert property (extRsp.done && regBusy && extRsp.status inside
    {SBI_EXT_NACK, SBI_EXT_CRC_BAD, SBI_EXT_TIMEOUT} |=> bootLoadFailed && !regBusy)
    else $error("abort not flagged");
  ok_stop_a: assert property (extRsp.done && regBusy && extRsp.status == SBI_EXT_OK
    |=> !regBusy && !bootLoadFailed) else $error("good load not ended");
endmodule
bind sbi_startup_regs sbi_startup_regs_checker #(.ROM_FULL_BYTES(ROM_FULL_BYTES)) chk (
  .clk(clk), .reset(reset), .ce(ce), .regWr(regWr), .regRd(regRd), .regRdValid(regRdValid),
  .regBusy(regBusy), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .romRdReq(romRdReq), .romRdValid(romRdValid), .bootFailClear(bootFailClear),
  .bootDone(bootDone), .bootLoadFailed(bootLoadFailed), .romRdAddr(romRdAddr),
  .romRdData(romRdData), .extReq(extReq), .extRsp(extRsp), .cfgWr(cfgWr),
  .configCode(configCode));
`default_nettype wire

// [sbi_boot_model.sv]
// Internal memory and boot memory engine seen from the startup group
`timescale 1ns/1ps
`default_nettype none
module sbi_boot_model
  import sbi_pkg::*;
(
  // Clock, reset and scenario setup
  input wire logic            clk, reset, slow,
  input wire logic [7:0]      rom0, rom1,
  input wire logic [3:0]      arbLoss,
  input wire sbi_ext_status_e finStat,
  // Internal memory side
  input wire logic            romRdReq,
  input wire logic [7:0]      romRdAddr,
  output logic                romRdValid,
  output logic [7:0]          romRdData,
  // Boot memory engine side
  input wire sbi_ext_req_s    extReq,
  output sbi_ext_rsp_s        extRsp
);
  logic [7:0] a;   // Pending memory address
  int rw, ew, n;   // Memory wait, engine step, attempt count
  logic ok;        // Attempt will succeed

  // Memory image: first two bytes set per scenario
  function automatic logic [7:0] romByte(input logic [7:0] x);
    case (x)
      8'h00: return rom0;
      8'h01: return rom1;
      8'h02: return 8'h21;
      8'h03: return 8'h43;
      8'h04: return 8'h65;
      8'h05: return 8'h87;
      default: return x ^ 8'h5A;
    endcase
  endfunction

  // Data lines flip between answers so stale values never pass
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      romRdValid <= 1'b0; romRdData <= '0; extRsp <= '0; rw = -1; ew = -1; n = 0;
    end else begin
      romRdValid <= 1'b0;
      romRdData <= ~romRdData;
      extRsp.byteValid <= 1'b0;
      extRsp.done <= 1'b0;
      extRsp.data <= ~extRsp.data;
      if (romRdReq) begin a = romRdAddr; rw = slow ? 3 : 0; end
      else if (rw > 0) rw--;
      else if (rw == 0) begin romRdValid <= 1'b1; romRdData <= romByte(a); rw = -1; end
      if (extReq.start) begin n++; ew = 0; end
      else if (ew >= 0) begin
        ok = n > arbLoss && finStat == SBI_EXT_OK;
        if (ok && ew < 4) begin
          // Offsets 6, 8, 9 and the checksum place
          extRsp.byteValid <= 1'b1;
          extRsp.offset <= ew == 0 ? 8'h06 : ew == 3 ? 8'hE0 : 8'h07 + ew[7:0];
          extRsp.data <= 8'h3C ^ ew[7:0];
          ew++;
        end else begin
          extRsp.done <= 1'b1;
          extRsp.status <= ok ? SBI_EXT_OK : n <= arbLoss ? SBI_EXT_ARB_LOST : finStat;
          ew = -1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the startup and ID register group
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, act, exp); end end
module tb_top;
  import sbi_pkg::*;
  logic clk = 0, reset = 1, ce = 1, regWr = 0, regRd = 0, bootFailClear = 0, slow = 0;
  logic [15:0] regAddr = '0;
  logic [7:0] regWdata = '0, regRdata, romRdAddr, romRdData, rom0 = '0, rom1 = '0;
  logic regRdValid, regBusy, romRdReq, romRdValid, bootDone, bootLoadFailed;
  logic [10:0] configCode;
  sbi_ext_req_s extReq;
  sbi_ext_rsp_s extRsp;
  sbi_cfg_wr_s cfgWr;
  sbi_ext_status_e finStat = SBI_EXT_OK;
  logic [3:0] arbLoss = '0;
  int fail_count = 0, comparisons = 0, nRom, nStart, nCfg, c, i;
  logic [31:0] seed = 32'h0000_005B;
  logic [7:0] mem [6];  // Register model
  // Scenario table: first bytes, arbitration losses, final outcome
  logic [7:0] cr0 [6] = '{8'h0A, 8'h11, 8'h10, 8'h08, 8'h0C, 8'h00};
  logic [7:0] cr1 [6] = '{8'hD1, 8'h50, 8'h2A, 8'h50, 8'h63, 8'h50};
  int carb [6] = '{1, 0, 3, 0, 0, 0};
  sbi_ext_status_e cfs [6] = '{SBI_EXT_OK, SBI_EXT_OK, SBI_EXT_OK, SBI_EXT_NACK,
                               SBI_EXT_CRC_BAD, SBI_EXT_TIMEOUT};

  always #50 clk = ~clk;

  sbi_startup_regs #(.ROM_FULL_BYTES(8'h10)) uut (.clk(clk), .reset(reset), .ce(ce),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regRdValid(regRdValid), .regBusy(regBusy), .romRdReq(romRdReq),
    .romRdAddr(romRdAddr), .romRdValid(romRdValid), .romRdData(romRdData),
    .extReq(extReq), .extRsp(extRsp), .cfgWr(cfgWr), .bootFailClear(bootFailClear),
    .bootDone(bootDone), .bootLoadFailed(bootLoadFailed), .configCode(configCode));
  sbi_boot_model bm (.clk(clk), .reset(reset), .slow(slow), .rom0(rom0), .rom1(rom1),
    .arbLoss(arbLoss), .finStat(finStat), .romRdReq(romRdReq), .romRdAddr(romRdAddr),
    .romRdValid(romRdValid), .romRdData(romRdData), .extReq(extReq), .extRsp(extRsp));

  // Count boot traffic and check each boot memory request; pulses are settled at the falling edge
  always @(negedge clk) begin
    if (romRdReq) nRom++;
    if (cfgWr.valid) nCfg++;
    if (extReq.start) begin
      nStart++;
      `CHK(extReq.busAddr, rom1[6:0])
      `CHK(extReq.twoAddrBytes, rom1[7])
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Expected read value; reserved bits read zero
  function automatic logic [7:0] ex(input int a);
    return a == 0 ? mem[0] & 8'hFB : a == 5 ? mem[5] & 8'hFE : mem[a];
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk); regWr = 1; regAddr = a; regWdata = d;
    @(negedge clk); regWr = 0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk); regRd = 1; regAddr = a;
    @(negedge clk); regRd = 0;
    `CHK(regRdValid, 1'b1)
    `CHK(regRdata, e)
  endtask

  // Power-up boot with one scenario, then compare its outcome
  task automatic boot(input int s);
    int k, ret, ext, fl;
    @(negedge clk); reset = 1; rom0 = cr0[s]; rom1 = cr1[s];
    arbLoss = carb[s][3:0]; finStat = cfs[s]; slow = s[0];
    repeat (8) @(negedge clk);
    nRom = 0; nStart = 0; nCfg = 0; reset = 0;
    // Byte 5 is already loaded here, so a write that slipped through would show on read-back
    while (nRom < 7) @(negedge clk);
    @(negedge clk); regWr = 1; regRd = 1; regAddr = 16'h0005; regWdata = 8'hFF;
    @(negedge clk); regWr = 0; regRd = 0;
    `CHK(regRdValid, 1'b0)
    for (k = 0; k < 3000 && bootDone !== 1'b1; k++) @(negedge clk);
    ret = cr0[s][7:3]; ext = !cr0[s][0];
    fl = ext && (carb[s] > ret || cfs[s] != SBI_EXT_OK);
    `CHK(bootDone, 1'b1)
    `CHK(bootLoadFailed, fl[0])
    `CHK(nRom, cr0[s][1] ? 8 : 16)
    `CHK(nStart, ext ? (carb[s] > ret ? ret : carb[s]) + 1 : 0)
    `CHK(nCfg, (cr0[s][1] ? 2 : 10) + ((ext && !fl) ? 2 : 0))
    for (k = 0; k < 6; k++) mem[k] = bm.romByte(k[7:0]);
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog far beyond six boots and their register traffic
  initial begin
    #(100 * 30000);
    fail_count++;
    conclude;
  end

  initial begin
    for (c = 0; c < 6; c++) begin
      boot(c);
      for (i = 0; i < 6; i++) rd(i[15:0], ex(i));
      rd(16'h0006, 8'h00);
      for (i = 0; i < 6; i++) begin
        seed = xs(seed);
        mem[i] = i == 0 ? seed[7:0] & 8'hFB : seed[7:0];
        wr(i[15:0], mem[i]);
      end
      // A write while the clock enable is low must leave the register untouched
      ce = 0;
      wr(16'h0005, ~mem[5]);
      ce = 1;
      for (i = 0; i < 6; i++) rd(i[15:0], ex(i));
      `CHK(configCode, {mem[4][3:0], mem[5][7:1]})
      @(negedge clk); bootFailClear = 1;
      @(negedge clk); bootFailClear = 0;
      `CHK(bootLoadFailed, 1'b0)
    end
    conclude;
  end
endmodule
`default_nettype wire
